// ### rsc_pkg.sv
package rsc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the APB slave
    // ------------------------------------------------------------
    localparam logic [7:0] RSC_OFS_THRESHOLD = 8'h00; // Brownout threshold code
    localparam logic [7:0] RSC_OFS_WIDTH = 8'h04;     // Brownout minimum width select
    localparam logic [7:0] RSC_OFS_CAUSE = 8'h08;     // Sticky reset cause flags
    localparam logic [7:0] RSC_OFS_WDOG = 8'h0c;      // Watchdog control
    localparam logic [7:0] RSC_OFS_FLASH = 8'h10;     // Flash control two (key)
    localparam logic [7:0] RSC_OFS_RSTCTL = 8'h14;    // Reset control code
    localparam logic [7:0] RSC_OFS_PWRSTAT = 8'h18;   // Timeout and power-down flags
    localparam logic [7:0] RSC_OFS_IRQSTAT = 8'h1c;   // Event status, read clears
    localparam logic [7:0] RSC_OFS_IRQMASK = 8'h20;   // Event mask

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RSC_THR_2V10 = 8'h55;      // Also the power-on value
    localparam logic [7:0] RSC_THR_2V55 = 8'h33;
    localparam logic [7:0] RSC_THR_3V15 = 8'h99;
    localparam logic [7:0] RSC_THR_3V80 = 8'haa;
    localparam logic [1:0] RSC_WIDTH_RST = 2'h1;      // 31-32 slow periods
    localparam logic [4:0] RSC_WDOG_ON = 5'h0a;       // 01010b, also power-on value
    localparam logic [4:0] RSC_WDOG_OFF = 5'h15;      // 10101b
    localparam logic [2:0] RSC_WDOG_DIV_RST = 3'h3;   // Low bits of watchdog control
    localparam logic [7:0] RSC_RSTCTL_A = 8'h55;      // Valid, also power-on value
    localparam logic [7:0] RSC_RSTCTL_B = 8'haa;
    localparam logic [7:0] RSC_FLASH_KEY = 8'h55;     // Whole-device reset key
    localparam logic [3:0] RSC_CAUSE_RST = 4'h0;      // Brownout flag taken as 0

    // Cause flag bit positions
    localparam int RSC_CF_WDOG = 0;
    localparam int RSC_CF_INVSEL = 1;
    localparam int RSC_CF_BROWN = 2;
    localparam int RSC_CF_CTRL = 3;

    // Event bit positions in status and mask registers
    localparam int RSC_EV_BROWN = 0;
    localparam int RSC_EV_INVSEL = 1;
    localparam int RSC_EV_WDCTL = 2;
    localparam int RSC_EV_RSTCTL = 3;
    localparam int RSC_EV_FLASH = 4;
    localparam int RSC_EV_WDRUN = 5;
    localparam int RSC_EV_WDSLP = 6;
    localparam int RSC_EV_NUM = 7;

    // ------------------------------------------------------------
    // Timing, in slow oscillator periods or clk cycles
    // ------------------------------------------------------------
    localparam logic [7:0] RSC_BO_TICKS_00 = 8'd8;    // Gives 7-8 periods
    localparam logic [7:0] RSC_BO_TICKS_01 = 8'd32;   // Gives 31-32 periods
    localparam logic [7:0] RSC_BO_TICKS_10 = 8'd64;   // Gives 63-64 periods
    localparam logic [7:0] RSC_BO_TICKS_11 = 8'd128;  // Gives 127-128 periods
    localparam logic [3:0] RSC_SOFT_TICKS = 4'd4;     // Software-reset delay
    localparam logic [3:0] RSC_HOLD_CYCLES = 4'd8;    // Reset output hold time

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        RSC_ST_RUN = 3'b001,
        RSC_ST_DELAY = 3'b010,
        RSC_ST_HOLD = 3'b100
    } rsc_state_t;

endpackage

// ### rsc_bo_if.sv
`timescale 1ns/10ps
// Link between the sequencer and the brownout width filter
interface rsc_bo_if;
    logic supply_low;   // Synchronised low-supply level
    logic slow_tick;    // One pulse per slow oscillator period
    logic enable;       // Detection active (run modes only)
    logic [1:0] width;  // Width code field
    logic fire;         // One pulse when a qualified brownout is seen
    modport seq (output supply_low, output slow_tick, output enable, output width, input fire);
    modport filt (input supply_low, input slow_tick, input enable, input width, output fire);
endinterface

// ### rsc_bo_filter.sv
`timescale 1ns/10ps
module rsc_bo_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Sequencer side
    rsc_bo_if.filt bo
);
    import rsc_pkg::*;

    // ------------------------------------------------------------
    // Width qualification
    // ------------------------------------------------------------
    logic [7:0] cnt;        // Slow periods seen while low
    logic fired;            // Already reported this low episode
    logic [7:0] next_cnt;
    logic next_fired;
    logic next_fire;
    logic fire_q;           // Registered pulse

    // Tick limit for a width code
    function automatic logic [7:0] limit_of(input logic [1:0] code);
        case (code)
            2'h0: limit_of = RSC_BO_TICKS_00;
            2'h1: limit_of = RSC_BO_TICKS_01;
            2'h2: limit_of = RSC_BO_TICKS_10;
            default: limit_of = RSC_BO_TICKS_11;
        endcase
    endfunction

    // First tick lands anywhere in a period, hence the one-period spread
    always_comb begin
        next_cnt = cnt;
        next_fired = fired;
        next_fire = 1'b0;
        if (!bo.supply_low || !bo.enable) begin
            // Short dips are forgotten entirely
            next_cnt = 8'h00;
            next_fired = 1'b0;
        end else if (cnt == limit_of(bo.width)) begin
            next_fire = !fired;
            next_fired = 1'b1;
        end else if (bo.slow_tick) begin
            next_cnt = cnt + 8'h01;
        end
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
            fired <= 1'b0;
            fire_q <= 1'b0;
        end else if (ce) begin
            cnt <= next_cnt;
            fired <= next_fired;
            fire_q <= next_fire;
        end
    end

    assign bo.fire = fire_q;
endmodule

// ### rsc_top.sv
`timescale 1ns/10ps
module rsc_top (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event sources
    input wire logic supply_low_pin,
    input wire logic slow_tick,
    input wire logic wdog_timeout,
    input wire logic sleep_mode,
    // Reset and control outputs
    output logic core_reset,
    output logic periph_reset,
    output logic pc_sp_clear,
    output logic wdog_enable,
    output logic [1:0] threshold_index,
    output logic irq
);
    import rsc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rsc_bo_if bo_link();            // Link to width filter
    logic low_meta;                 // Synchroniser first stage
    logic low_sync;                 // Synchroniser second stage
    rsc_state_t state;              // Sequencer state
    rsc_state_t next_state;
    logic [3:0] delay_cnt;          // Soft-reset delay ticks
    logic [3:0] next_delay_cnt;
    logic [3:0] hold_cnt;           // Reset hold cycles
    logic [3:0] next_hold_cnt;
    logic hold_sleep;               // Hold is PC/SP only
    logic next_hold_sleep;
    logic [7:0] threshold_code_field;
    logic [7:0] next_threshold;
    logic [1:0] width_code_field;
    logic [1:0] next_width;
    logic [3:0] reset_cause_flags;
    logic [3:0] next_cause;
    logic [4:0] watchdog_enable_field;
    logic [4:0] next_wdog;
    logic [2:0] wdog_div;           // Low watchdog control bits, stored only
    logic [2:0] next_wdog_div;
    logic [7:0] flash_control_two;
    logic [7:0] next_flash;
    logic [7:0] reset_ctrl;         // Reset control code
    logic [7:0] next_rstctl;
    logic timeout_status_flag;
    logic next_to;
    logic powerdown_status_flag;
    logic next_pdf;
    logic [RSC_EV_NUM-1:0] irq_status;
    logic [RSC_EV_NUM-1:0] next_irq_status;
    logic [RSC_EV_NUM-1:0] irq_mask;
    logic [RSC_EV_NUM-1:0] next_irq_mask;
    logic [RSC_EV_NUM-1:0] events;  // One-cycle event strobes
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic wr_en;                    // Write completes this edge
    logic rd_en;                    // Read completes this edge
    logic bad_thr;
    logic bad_wdog;
    logic bad_rstctl;

    // Defined threshold code test, used for the validity check only, not for the index
    function automatic logic thr_valid(input logic [7:0] code);
        thr_valid = (code == RSC_THR_2V10) || (code == RSC_THR_2V55) ||
                    (code == RSC_THR_3V15) || (code == RSC_THR_3V80);
    endfunction

    // Address in the register map
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            RSC_OFS_THRESHOLD, RSC_OFS_WIDTH, RSC_OFS_CAUSE, RSC_OFS_WDOG,
            RSC_OFS_FLASH, RSC_OFS_RSTCTL, RSC_OFS_PWRSTAT, RSC_OFS_IRQSTAT,
            RSC_OFS_IRQMASK: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Supply comparator synchroniser
    // ------------------------------------------------------------
    // Comparator is analog and asynchronous to clk
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_meta <= 1'b0;
            low_sync <= 1'b0;
        end else if (ce) begin
            low_meta <= supply_low_pin;
            low_sync <= low_meta;
        end
    end

    // Brownout detection is off in sleep and outside the run state
    assign bo_link.supply_low = low_sync;
    assign bo_link.slow_tick = slow_tick;
    assign bo_link.enable = !sleep_mode && (state == RSC_ST_RUN);
    assign bo_link.width = width_code_field;

    rsc_bo_filter u_filter (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .bo(bo_link.filt)
    );

    // ------------------------------------------------------------
    // APB access decode
    // ------------------------------------------------------------
    // One wait state: pready is a flop, so each transfer takes two access edges
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && pready && !pwrite;

    // Read mux and handshake
    always_comb begin
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        if (psel && penable && !pready) begin
            next_pslverr = !addr_mapped(paddr);
            case (paddr)
                RSC_OFS_THRESHOLD: next_prdata[7:0] = threshold_code_field;
                RSC_OFS_WIDTH: next_prdata[1:0] = width_code_field;
                RSC_OFS_CAUSE: next_prdata[3:0] = reset_cause_flags;
                RSC_OFS_WDOG: next_prdata[7:0] = {watchdog_enable_field, wdog_div};
                RSC_OFS_FLASH: next_prdata[7:0] = flash_control_two;
                RSC_OFS_RSTCTL: next_prdata[7:0] = reset_ctrl;
                RSC_OFS_PWRSTAT: next_prdata[1:0] = {powerdown_status_flag,
                                                     timeout_status_flag};
                RSC_OFS_IRQSTAT: next_prdata[RSC_EV_NUM-1:0] = irq_status;
                RSC_OFS_IRQMASK: next_prdata[RSC_EV_NUM-1:0] = irq_mask;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus response registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Reset sequencer and register file
    // ------------------------------------------------------------
    assign bad_thr = !thr_valid(threshold_code_field);
    assign bad_wdog = (watchdog_enable_field != RSC_WDOG_ON) &&
                      (watchdog_enable_field != RSC_WDOG_OFF);
    assign bad_rstctl = (reset_ctrl != RSC_RSTCTL_A) && (reset_ctrl != RSC_RSTCTL_B);

    always_comb begin
        next_state = state;
        next_delay_cnt = delay_cnt;
        next_hold_cnt = hold_cnt;
        next_hold_sleep = hold_sleep;
        next_threshold = threshold_code_field;
        next_width = width_code_field;
        next_cause = reset_cause_flags;
        next_wdog = watchdog_enable_field;
        next_wdog_div = wdog_div;
        next_flash = flash_control_two;
        next_rstctl = reset_ctrl;
        next_to = timeout_status_flag;
        next_pdf = powerdown_status_flag;
        next_irq_mask = irq_mask;
        events = '0;
        // Software writes first, so hardware sets below win
        if (wr_en) begin
            case (paddr)
                RSC_OFS_THRESHOLD: next_threshold = pwdata[7:0];
                RSC_OFS_WIDTH: next_width = pwdata[1:0];
                RSC_OFS_CAUSE: next_cause = reset_cause_flags & pwdata[3:0];
                RSC_OFS_WDOG: begin
                    next_wdog = pwdata[7:3];
                    next_wdog_div = pwdata[2:0];
                end
                RSC_OFS_FLASH: next_flash = pwdata[7:0];
                RSC_OFS_RSTCTL: next_rstctl = pwdata[7:0];
                RSC_OFS_IRQMASK: next_irq_mask = pwdata[RSC_EV_NUM-1:0];
                default: ;
            endcase
        end
        case (state)
            RSC_ST_RUN: begin
                if (bo_link.fire) begin
                    // Full reset; threshold code and status flags kept
                    events[RSC_EV_BROWN] = 1'b1;
                    next_cause[RSC_CF_BROWN] = 1'b1;
                    next_state = RSC_ST_HOLD;
                    next_hold_sleep = 1'b0;
                    next_hold_cnt = 4'h0;
                    next_width = RSC_WIDTH_RST;
                    next_wdog = RSC_WDOG_ON;
                    next_wdog_div = RSC_WDOG_DIV_RST;
                    next_rstctl = RSC_RSTCTL_A;
                end else if (wdog_timeout && sleep_mode) begin
                    // Only PC and SP cleared; timeout and power-down flags set, everything else kept
                    events[RSC_EV_WDSLP] = 1'b1;
                    next_to = 1'b1;
                    next_pdf = 1'b1;
                    next_state = RSC_ST_HOLD;
                    next_hold_sleep = 1'b1;
                    next_hold_cnt = 4'h0;
                end else if (wdog_timeout ||
                             (wr_en && paddr == RSC_OFS_FLASH && pwdata[7:0] == RSC_FLASH_KEY)) begin
                    events[RSC_EV_WDRUN] = wdog_timeout;
                    events[RSC_EV_FLASH] = !wdog_timeout;
                    next_to = timeout_status_flag | wdog_timeout;
                    next_state = RSC_ST_HOLD;
                    next_hold_sleep = 1'b0;
                    next_hold_cnt = 4'h0;
                    next_threshold = RSC_THR_2V10;
                    next_width = RSC_WIDTH_RST;
                    next_wdog = RSC_WDOG_ON;
                    next_wdog_div = RSC_WDOG_DIV_RST;
                    next_rstctl = RSC_RSTCTL_A;
                end else if (bad_thr || bad_wdog || bad_rstctl) begin
                    next_state = RSC_ST_DELAY;
                    next_delay_cnt = 4'h0;
                end
            end
            RSC_ST_DELAY: begin
                if (slow_tick && delay_cnt != RSC_SOFT_TICKS) begin
                    next_delay_cnt = delay_cnt + 4'h1;
                end else if (delay_cnt == RSC_SOFT_TICKS) begin
                    // Codes sampled at expiry; a repaired code still resets
                    next_state = RSC_ST_HOLD;
                    next_hold_sleep = 1'b0;
                    next_hold_cnt = 4'h0;
                    next_cause[RSC_CF_INVSEL] = reset_cause_flags[RSC_CF_INVSEL] | bad_thr;
                    next_cause[RSC_CF_WDOG] = reset_cause_flags[RSC_CF_WDOG] | bad_wdog;
                    next_cause[RSC_CF_CTRL] = reset_cause_flags[RSC_CF_CTRL] | bad_rstctl;
                    events[RSC_EV_INVSEL] = bad_thr;
                    events[RSC_EV_WDCTL] = bad_wdog;
                    events[RSC_EV_RSTCTL] = bad_rstctl;
                    next_threshold = RSC_THR_2V10;
                    next_width = RSC_WIDTH_RST;
                    next_wdog = RSC_WDOG_ON;
                    next_wdog_div = RSC_WDOG_DIV_RST;
                    next_rstctl = RSC_RSTCTL_A;
                end
            end
            RSC_ST_HOLD: begin
                // Fixed hold so downstream logic sees a clean reset level
                if (hold_cnt == RSC_HOLD_CYCLES - 4'h1) begin
                    next_state = RSC_ST_RUN;
                end else begin
                    next_hold_cnt = hold_cnt + 4'h1;
                end
            end
            default: begin
                next_state = RSC_ST_HOLD;
                next_hold_cnt = 4'h0;
            end
        endcase
        // Read clears, but an event in the same cycle survives
        next_irq_status = ((rd_en && paddr == RSC_OFS_IRQSTAT) ? '0 : irq_status) | events;
    end

    // Power-on: hold full reset, flags clear, registers to defaults
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= RSC_ST_HOLD;
            delay_cnt <= 4'h0;
            hold_cnt <= 4'h0;
            hold_sleep <= 1'b0;
            threshold_code_field <= RSC_THR_2V10;
            width_code_field <= RSC_WIDTH_RST;
            reset_cause_flags <= RSC_CAUSE_RST;
            watchdog_enable_field <= RSC_WDOG_ON;
            wdog_div <= RSC_WDOG_DIV_RST;
            flash_control_two <= 8'h00;
            reset_ctrl <= RSC_RSTCTL_A;
            timeout_status_flag <= 1'b0;
            powerdown_status_flag <= 1'b0;
            irq_status <= '0;
            irq_mask <= '0;
        end else if (ce) begin
            state <= next_state;
            delay_cnt <= next_delay_cnt;
            hold_cnt <= next_hold_cnt;
            hold_sleep <= next_hold_sleep;
            threshold_code_field <= next_threshold;
            width_code_field <= next_width;
            reset_cause_flags <= next_cause;
            watchdog_enable_field <= next_wdog;
            wdog_div <= next_wdog_div;
            flash_control_two <= next_flash;
            reset_ctrl <= next_rstctl;
            timeout_status_flag <= next_to;
            powerdown_status_flag <= next_pdf;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Outputs follow the next state so they line up with it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_reset <= 1'b1;
            periph_reset <= 1'b1;
            pc_sp_clear <= 1'b0;
            wdog_enable <= 1'b0;
            threshold_index <= 2'h0;
            irq <= 1'b0;
        end else if (ce) begin
            core_reset <= (next_state == RSC_ST_HOLD) && !next_hold_sleep;
            periph_reset <= (next_state == RSC_ST_HOLD) && !next_hold_sleep;
            pc_sp_clear <= (next_state == RSC_ST_HOLD) && next_hold_sleep;
            wdog_enable <= (next_wdog == RSC_WDOG_ON);
            case (next_threshold)
                RSC_THR_2V55: threshold_index <= 2'h1;
                RSC_THR_3V15: threshold_index <= 2'h2;
                RSC_THR_3V80: threshold_index <= 2'h3;
                default: threshold_index <= 2'h0;
            endcase
            irq <= |(next_irq_status & next_irq_mask);
        end
    end
endmodule

// ### rsc_top_properties.sv
`timescale 1ns/10ps
// ------------------------------
// Port checks of the sequencer
// ------------------------------
module rsc_chk
    import rsc_pkg::*;
(
    input logic clk, arst_n, ce, psel, penable, pwrite, pready, pslverr,
    input logic [7:0] paddr,
    input logic [31:0] pwdata, prdata,
    input logic supply_low_pin, slow_tick, wdog_timeout, sleep_mode, irq,
    input logic core_reset, periph_reset, pc_sp_clear, wdog_enable,
    input logic [1:0] threshold_index
);
    default clocking @(posedge clk); endclocking
    // A frozen clock enable stretches every sequence, so checks are disabled while it is low
    default disable iff (!arst_n || !ce);
    // Running with no reset output and supply_low_pin low, so an event is taken at once outside the soft-reset delay state
    logic calm;
    logic rdw;
    assign calm = !core_reset && !pc_sp_clear && !supply_low_pin;
    assign rdw = pready && !pwrite;
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after one wait");
    a_err_zero: assert property (pslverr |-> pready && prdata == 0)
        else $error("error reply carries data");
    a_hole_err: assert property (pready && paddr > 8'h20 |-> pslverr)
        else $error("unmapped place accepted");
    a_width_bits: assert property (rdw && paddr == RSC_OFS_WIDTH |-> prdata[31:2] == 0)
        else $error("width upper bits set");
    a_cause_bits: assert property (rdw && paddr == RSC_OFS_CAUSE |-> prdata[31:4] == 0)
        else $error("cause upper bits set");
    a_key_reset: assert property (calm && pready && pwrite && paddr == RSC_OFS_FLASH
        && pwdata[7:0] == RSC_FLASH_KEY |=> core_reset)
        else $error("key gave no reset");
    a_hold_len: assert property ($rose(core_reset) |-> core_reset [*8] ##1 !core_reset)
        else $error("hold length wrong");
    a_run_wdog: assert property (calm && wdog_timeout && !sleep_mode |=> core_reset)
        else $error("run timeout ignored");
    a_sleep_wdog: assert property (calm && wdog_timeout && sleep_mode
        |=> pc_sp_clear && !core_reset)
        else $error("sleep timeout wrong");
    a_reset_pair: assert property (core_reset == periph_reset)
        else $error("core and periph resets differ");
endmodule
bind rsc_top rsc_chk u_chk (.*);

// ### test_reset_source_controller.sv
`timescale 1ns/10ps
module test_reset_source_controller;
    import rsc_pkg::*;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, err, ce = 1;
    logic slow_tick = 0, wdog_timeout = 0, sleep_mode = 0, supply_low_pin = 0;
    logic pready, pslverr, core_reset, periph_reset, pc_sp_clear, wdog_enable, irq;
    logic [7:0] paddr = 0, lf = 8'h55;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0] threshold_index, div = 0;
    int n_fail = 0, n_tests = 0, n;
    int tk[4] = '{8, 32, 64, 128};
    logic [7:0] thr[4] = '{8'h55, 8'h33, 8'h99, 8'haa};
    logic [7:0] ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
    logic [7:0] rv[6] = '{8'h55, 8'h01, 8'h00, 8'h53, 8'h55, 8'h00};
    always #25 clk = ~clk;
    // Slow oscillator stand-in: one tick every fourth cycle
    always @(posedge clk) begin
        div <= div + 2'h1;
        slow_tick <= (div == 2'h3);
    end
    rsc_top dut (.*);
    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    // Waits a bounded time for a reset output, then past its hold
    task automatic ev(input logic e);
        n = 0;
        while (!(core_reset | pc_sp_clear) && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk(core_reset | pc_sp_clear, e);
        repeat (12) @(posedge clk);
    endtask
    task automatic final_report;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1;
        repeat (12) @(posedge clk);
        foreach (ofs[k]) begin
            apb(0, ofs[k], 0);
            chk(rd, {24'h0, rv[k]});
        end
        apb(1, RSC_OFS_WIDTH, {lf, 24'hfffffe});
        apb(0, RSC_OFS_WIDTH, 0);
        chk(rd, 32'h2);
        apb(0, 8'h24, 0);
        chk(err, 1); 
        foreach (thr[k]) begin
            apb(1, RSC_OFS_THRESHOLD, {24'h0, thr[k]});
            chk(threshold_index, k);
        end
        apb(1, RSC_OFS_WIDTH, 0);
        supply_low_pin <= 1;
        repeat (16) @(posedge clk);
        supply_low_pin <= 0;
        ev(0);
        foreach (tk[k]) begin
            apb(1, RSC_OFS_WIDTH, k);
            supply_low_pin <= 1;
            ev(1);
            supply_low_pin <= 0;
            chk(n >= 4 * tk[k] - 4 && n <= 4 * tk[k] + 8, 1);
        end
        apb(0, RSC_OFS_THRESHOLD, 0);
        chk(rd, 32'haa);
        apb(1, RSC_OFS_CAUSE, 32'hf);
        apb(0, RSC_OFS_CAUSE, 0);
        chk(rd, 32'h4);
        apb(1, RSC_OFS_CAUSE, 0);
        // Random undefined threshold code
        while (lf == 8'h55 || lf == 8'h33 || lf == 8'h99 || lf == 8'haa) lf = nx(lf);
        apb(1, RSC_OFS_THRESHOLD, {24'h0, lf});
        ev(1);
        apb(0, RSC_OFS_THRESHOLD, 0);
        chk(rd, 32'h55);
        apb(1, RSC_OFS_WDOG, 32'hab);
        chk(wdog_enable, 0);
        apb(1, RSC_OFS_WDOG, 32'h53);
        chk(wdog_enable, 1);
        apb(1, RSC_OFS_WDOG, 32'h03);
        ev(1);
        apb(0, RSC_OFS_CAUSE, 0);
        chk(rd, 32'h3);
        // Bad reset control code takes the same delayed path
        apb(1, RSC_OFS_RSTCTL, {24'h0, lf});
        ev(1);
        apb(0, RSC_OFS_CAUSE, 0);
        chk(rd, 32'hb);
        apb(0, RSC_OFS_RSTCTL, 0);
        chk(rd, 32'h55);
        apb(1, RSC_OFS_FLASH, 32'h55);
        ev(1);
        // Clock enable low: a timeout pulse in that cycle must be lost
        ce <= 0;
        wdog_timeout <= 1;
        @(posedge clk) wdog_timeout <= 0;
        @(posedge clk) ce <= 1;
        apb(0, RSC_OFS_PWRSTAT, 0);
        chk(rd, 0);
        chk(core_reset | pc_sp_clear, 0);
        for (int s = 0; s < 2; s++) begin
            sleep_mode <= s[0];
            wdog_timeout <= 1;
            @(posedge clk) wdog_timeout <= 0;
            ev(1);
            apb(0, RSC_OFS_PWRSTAT, 0);
            chk(rd, 2 * s + 1);
        end
        sleep_mode <= 0;
        supply_low_pin <= 1;
        ev(1);
        supply_low_pin <= 0;
        apb(0, RSC_OFS_PWRSTAT, 0);
        chk(rd, 32'h3);
        chk(irq, 0);
        apb(1, RSC_OFS_IRQMASK, 32'h7f);
        chk(irq, 1);
        apb(0, RSC_OFS_IRQSTAT, 0);
        chk(rd, 32'h7f);
        chk(irq, 0);
        // Second power-on in mid-run: flags must come back cleared
        arst_n <= 0;
        repeat (2) @(posedge clk);
        chk(core_reset & periph_reset, 1);
        arst_n <= 1;
        repeat (12) @(posedge clk);
        chk(core_reset | periph_reset, 0);
        apb(0, RSC_OFS_PWRSTAT, 0);
        chk(rd, 0);
        apb(0, RSC_OFS_CAUSE, 0);
        chk(rd, 0);
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report;
    end
endmodule
